/* File: core/ccad_pkg.sv */
package ccad_pkg;
   // =====================================================================
   // address decode constants
   // =====================================================================
   localparam int          ADDR_WIDTH      = 11;           // A10..A0
   localparam logic [10:0] CFG_BASE_ADDR   = 11'h200;      // bank base in attribute space
   localparam logic [10:0] OPTION_ADDR     = 11'h200;      // card_option_control
   localparam logic [10:0] STATE_ADDR      = 11'h202;      // card_state_control
   localparam logic [10:0] PINSUB_ADDR     = 11'h204;      // pin_substitute_status
   localparam logic [10:0] SOCKET_ADDR     = 11'h206;      // socket_copy_number
   localparam logic [1:0]  SEL_OPTION      = 2'h0;         // A2:A1 codes
   localparam logic [1:0]  SEL_STATE       = 2'h1;
   localparam logic [1:0]  SEL_PINSUB      = 2'h2;
   localparam logic [1:0]  SEL_SOCKET      = 2'h3;
   // =====================================================================
   // option register fields and reset values
   // =====================================================================
   localparam int          SOFT_RESET_POS  = 7;            // soft_reset_bit
   localparam int          INT_TYPE_POS    = 6;            // interrupt_type_bit
   localparam logic [7:0]  OPTION_RESET    = 8'h00;
   localparam logic [7:0]  STATE_RESET     = 8'h00;
   localparam logic [7:0]  PINSUB_RESET    = 8'h00;
   localparam logic [7:0]  SOCKET_RESET    = 8'h00;
   // =====================================================================
   // card modes from the configuration index
   // =====================================================================
   typedef enum logic [1:0] {
      CCAD_MODE_MEMORY     = 2'h0,
      CCAD_MODE_CONTIG_IO  = 2'h1,
      CCAD_MODE_PRIMARY_IO = 2'h2,
      CCAD_MODE_SECOND_IO  = 2'h3
   } ccad_mode_type;
   // bus access classes
   typedef enum logic [2:0] {
      CCAD_ACC_IDLE    = 3'h0,
      CCAD_ACC_CFG     = 3'h1,
      CCAD_ACC_INFO    = 3'h3,
      CCAD_ACC_COMMON  = 3'h2,
      CCAD_ACC_INVALID = 3'h6
   } ccad_access_type;
endpackage : ccad_pkg

/* File: core/ccad_decode_if.sv */
// carries the decoded access from the decoder to the register bank
interface ccad_decode_if;
   import ccad_pkg::*;
   ccad_access_type accessKind;      // class of the current access
   logic            isRead;          // output strobe active
   logic            isWrite;         // write strobe active
   logic [1:0]      regSelect;       // A2:A1
   logic            lowLane;         // D7..D0 in use
   logic            highLane;        // D15..D8 in use
   modport decoder (output accessKind, isRead, isWrite, regSelect, lowLane, highLane);
   modport bank    (input  accessKind, isRead, isWrite, regSelect, lowLane, highLane);
endinterface : ccad_decode_if

/* File: core/ccad_access_decode.sv */
module ccad_access_decode
   import ccad_pkg::*;
(
   // host strobes
   input wire logic                  lowByteEnable_n,
   input wire logic                  highByteEnable_n,
   input wire logic                  attrSelect_n,
   input wire logic                  outputEnable_n,
   input wire logic                  writeEnable_n,
   input wire logic [ADDR_WIDTH-1:0] address,
   // decoded result
   ccad_decode_if.decoder            dec
);
   // =====================================================================
   // combinational decode of one bus access
   // =====================================================================
   always_comb begin
      dec.isRead    = ~outputEnable_n & writeEnable_n;
      dec.isWrite   = ~writeEnable_n & outputEnable_n;
      dec.regSelect = address[2:1];
      dec.lowLane   = 1'b0;
      dec.highLane  = 1'b0;
      dec.accessKind = CCAD_ACC_IDLE;
      if (lowByteEnable_n && highByteEnable_n) begin
         // standby: strobes ignored
         dec.accessKind = CCAD_ACC_IDLE;
      end else if (!(dec.isRead || dec.isWrite)) begin
         dec.accessKind = CCAD_ACC_IDLE;
      end else if (attrSelect_n) begin
         // common memory, lanes by enable
         dec.lowLane  = ~lowByteEnable_n;
         dec.highLane = ~highByteEnable_n;
         if (!lowByteEnable_n && !highByteEnable_n && address[0]) begin
            dec.accessKind = CCAD_ACC_INVALID;
         end else begin
            dec.accessKind = CCAD_ACC_COMMON;
         end
      end else if (lowByteEnable_n || address[0]) begin
         // odd attribute byte
         dec.accessKind = CCAD_ACC_INVALID;
      end else if (address[10:3] == CFG_BASE_ADDR[10:3]) begin
         // configuration bank
         dec.lowLane    = 1'b1;
         dec.accessKind = CCAD_ACC_CFG;
      end else if (!address[10] && !address[9]) begin
         // information structure, read only
         dec.lowLane    = dec.isRead;
         dec.accessKind = dec.isRead ? CCAD_ACC_INFO : CCAD_ACC_INVALID;
      end else begin
         // reserved attribute location
         dec.accessKind = CCAD_ACC_INVALID;
      end
   end
endmodule : ccad_access_decode

/* File: core/card_config_attr_decode.sv */
// Summary of operation
// - four config registers at attribute 200h
// - common memory lanes chosen by byte enables
// - option register at 200h read/write
// - A2:A1 select state, pins, socket registers
// - information structure read at even low addresses
// - odd attribute byte reads are invalid
// - info writes and odd writes invalid
// - other attribute locations reserved, no function
// - I/O mode exposes pin status in registers
// - soft reset bit holds card in reset
// - clearing soft reset leaves card unconfigured
// - soft reset cleared by hardware reset
// - interrupt type bit: 1 level, 0 pulse
// - configuration index picks card mode
module card_config_attr_decode
   import ccad_pkg::*;
#(
   parameter int INFO_DEPTH = 256                  // information structure bytes
)
(
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      reset_n,
   // host bus strobes
   input  wire logic                      low_byte_enable_n,
   input  wire logic                      high_byte_enable_n,
   input  wire logic                      attrSelect_n,
   input  wire logic                      outputEnable_n,
   input  wire logic                      writeEnable_n,
   input  wire logic [ccad_pkg::ADDR_WIDTH-1:0] address,
   // data bus, three signals per lane
   input  wire logic [15:0]               dataIn,
   output logic      [15:0]               dataOut,
   output logic      [1:0]                dataOe_n,
   // common memory side
   input  wire logic [15:0]               commonReadData,
   output logic                           commonWrite,
   output logic      [15:0]               commonWriteData,
   output logic      [1:0]                commonLanes,
   // card state towards the core
   input  wire logic                      cardReady,
   input  wire logic                      writeProtect,
   output logic                           cardInReset,
   output logic                           levelInterrupt,
   output ccad_pkg::ccad_mode_type        cardMode,
   output logic                           ioMode,
   output logic                           invalidAccess
);
   // =====================================================================
   // decode and state
   // =====================================================================
   ccad_decode_if dec ();                           // decoded access

   typedef struct packed {
      logic [7:0]  option;                          // card_option_control
      logic [7:0]  cardState;                       // card_state_control
      logic [7:0]  pinSubstitute;                   // pin_substitute_status
      logic [7:0]  socketCopy;                      // socket_copy_number
      logic [15:0] dataOut;                         // registered read data
      logic [1:0]  dataOe_n;                        // lane drive enables, low drives
      logic        commonWrite;                     // common memory write pulse
      logic [15:0] commonWriteData;                 // write data to common memory
      logic [1:0]  commonLanes;                     // lanes of that write
      logic        writeSeen;                       // write strobe already acted on
      logic        invalidAccess;                   // invalid access flag (pulse)
      logic        cardInReset;                     // soft reset driven to card
      logic        ioMode;                          // index nonzero, I/O card mode
   } ccad_state_type;

   ccad_state_type state;                           // current state
   ccad_state_type next_state;                      // next state

   logic [7:0] infoMem [INFO_DEPTH];                // information structure bytes
   logic [7:0] cfgRead;                             // selected config byte
   logic [7:0] infoRead;                            // info byte at address

   ccad_access_decode u_decode (
      .lowByteEnable_n  (low_byte_enable_n),
      .highByteEnable_n (high_byte_enable_n),
      .attrSelect_n     (attrSelect_n),
      .outputEnable_n   (outputEnable_n),
      .writeEnable_n    (writeEnable_n),
      .address          (address),
      .dec              (dec.decoder)
   );

   // information structure contents: blank until loaded by a variant
   initial begin
      for (int i = 0; i < INFO_DEPTH; i++) begin
         infoMem[i] = 8'hff;
      end
   end
   assign infoRead = infoMem[address[$clog2(INFO_DEPTH):1]];

   // =====================================================================
   // register read mux
   // =====================================================================
   always_comb begin
      unique case (dec.regSelect)
         SEL_OPTION: cfgRead = state.option;
         SEL_STATE:  cfgRead = state.cardState;
         // I/O mode shows ready and protect here, not on pins
         SEL_PINSUB: cfgRead = ioMode ? {state.pinSubstitute[7:6],
                                         cardReady, writeProtect,
                                         state.pinSubstitute[3:0]}
                                      : state.pinSubstitute;
         SEL_SOCKET: cfgRead = state.socketCopy;
      endcase
   end

   // =====================================================================
   // next-state logic
   // =====================================================================
   always_comb begin
      next_state = state;
      next_state.commonWrite   = 1'b0;
      next_state.invalidAccess = 1'b0;
      next_state.dataOe_n      = 2'h3;
      next_state.dataOut       = 16'h0000;
      if (!dec.isWrite) begin
         next_state.writeSeen = 1'b0;
      end
      unique case (dec.accessKind)
         CCAD_ACC_IDLE: begin
            // lanes stay released
         end
         CCAD_ACC_CFG: begin
            if (dec.isRead) begin
               next_state.dataOut  = {8'h00, cfgRead};
               next_state.dataOe_n = 2'h2;
            end else if (!state.writeSeen) begin
               next_state.writeSeen = 1'b1;
               unique case (dec.regSelect)
                  // soft reset stays as written, no self clear
                  SEL_OPTION: begin
                     next_state.option = dataIn[7:0];
                     // clearing soft reset drops the index back to unconfigured
                     if (state.option[SOFT_RESET_POS] && !dataIn[SOFT_RESET_POS]) begin
                        next_state.option = OPTION_RESET;
                     end
                  end
                  SEL_STATE:  next_state.cardState     = dataIn[7:0];
                  SEL_PINSUB: next_state.pinSubstitute = dataIn[7:0];
                  SEL_SOCKET: next_state.socketCopy    = dataIn[7:0];
               endcase
            end
         end
         CCAD_ACC_INFO: begin
            next_state.dataOut  = {8'h00, infoRead};
            next_state.dataOe_n = 2'h2;
         end
         CCAD_ACC_COMMON: begin
            if (dec.isRead) begin
               // drive only the enabled lanes
               next_state.dataOut  = commonReadData;
               next_state.dataOe_n = ~{dec.highLane, dec.lowLane};
            end else if (!state.writeSeen) begin
               next_state.writeSeen       = 1'b1;
               next_state.commonWrite     = 1'b1;
               next_state.commonWriteData = dataIn;
               next_state.commonLanes     = {dec.highLane, dec.lowLane};
            end
         end
         default: begin
            // invalid or reserved: nothing stored, lanes released
            next_state.invalidAccess = 1'b1;
         end
      endcase
      // card held in reset while the bit stands; release is unconfigured
      next_state.cardInReset = next_state.option[SOFT_RESET_POS];
      // mode flag kept in a flop so the output comes straight from one
      next_state.ioMode      = |next_state.option[5:0];
   end

   // =====================================================================
   // state register; hardware reset clears soft reset and index
   // =====================================================================
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state               <= '0;
         state.option        <= OPTION_RESET;
         state.cardState     <= STATE_RESET;
         state.pinSubstitute <= PINSUB_RESET;
         state.socketCopy    <= SOCKET_RESET;
         state.dataOe_n      <= 2'h3;
      end else begin
         state <= next_state;
      end
   end

   // =====================================================================
   // outputs, all from flip-flops
   // =====================================================================
   assign dataOut         = state.dataOut;
   assign dataOe_n        = state.dataOe_n;
   assign commonWrite     = state.commonWrite;
   assign commonWriteData = state.commonWriteData;
   assign commonLanes     = state.commonLanes;
   assign cardInReset     = state.cardInReset;
   assign levelInterrupt  = state.option[INT_TYPE_POS];
   assign cardMode        = ccad_mode_type'(state.option[1:0]);
   assign ioMode          = state.ioMode;
   assign invalidAccess   = state.invalidAccess;

   // =====================================================================
   // assertions
   // =====================================================================
   sequence cfgWriteReset;
      dec.accessKind == CCAD_ACC_CFG && dec.isWrite && !state.writeSeen
         && dec.regSelect == SEL_OPTION && dataIn[SOFT_RESET_POS];
   endsequence
   // first cycle of a write strobe aimed at the option register
   sequence cfgWriteOption;
      dec.accessKind == CCAD_ACC_CFG && dec.isWrite && !state.writeSeen
         && dec.regSelect == SEL_OPTION;
   endsequence
   // option write that does not clear a standing soft reset, index taken as written
   sequence cfgWriteIndex;
      cfgWriteOption ##0 !(state.option[SOFT_RESET_POS] && !dataIn[SOFT_RESET_POS]);
   endsequence
   // option write that clears a standing soft reset
   sequence cfgWriteRelease;
      cfgWriteOption ##0 (state.option[SOFT_RESET_POS] && !dataIn[SOFT_RESET_POS]);
   endsequence

   a_soft_reset_set: assert property (@(posedge mclk) disable iff (!reset_n)
      cfgWriteReset |=> cardInReset)
      else $error("soft reset write did not reset card");
   a_soft_reset_hold: assert property (@(posedge mclk) disable iff (!reset_n)
      cardInReset && !(dec.accessKind == CCAD_ACC_CFG && dec.isWrite) |=> cardInReset)
      else $error("soft reset cleared itself");
   a_standby_release: assert property (@(posedge mclk) disable iff (!reset_n)
      low_byte_enable_n && high_byte_enable_n |=> dataOe_n == 2'h3 && !commonWrite)
      else $error("bus driven in standby");
   a_info_no_write: assert property (@(posedge mclk) disable iff (!reset_n)
      !attrSelect_n && !writeEnable_n && outputEnable_n && !low_byte_enable_n
         && address[10:9] == 2'h0 |=> invalidAccess && $stable(state.option))
      else $error("info structure write accepted");
   a_odd_read_bad: assert property (@(posedge mclk) disable iff (!reset_n)
      !attrSelect_n && !outputEnable_n && writeEnable_n && low_byte_enable_n
         && !high_byte_enable_n |=> invalidAccess && dataOe_n == 2'h3)
      else $error("odd attribute read served");
   a_cfg_read_lane: assert property (@(posedge mclk) disable iff (!reset_n)
      dec.accessKind == CCAD_ACC_CFG && dec.isRead |=> dataOe_n == 2'h2)
      else $error("config read not on low lane");
   a_common_hi_lane: assert property (@(posedge mclk) disable iff (!reset_n)
      attrSelect_n && !outputEnable_n && writeEnable_n && low_byte_enable_n
         && !high_byte_enable_n |=> dataOe_n == 2'h1)
      else $error("high lane not driven alone");
   a_mode_follows: assert property (@(posedge mclk) disable iff (!reset_n)
      cfgWriteIndex |=> ioMode == ($past(dataIn[5:0]) != 6'h00)
         && cardMode == ccad_mode_type'($past(dataIn[1:0])))
      else $error("mode does not follow index");
   a_release_unconfig: assert property (@(posedge mclk) disable iff (!reset_n)
      cfgWriteRelease |=> !cardInReset && !ioMode && !levelInterrupt)
      else $error("soft reset release left card configured");
endmodule : card_config_attr_decode

/* File: testbench/ccad_host_model.sv */
// host socket model: one access at a time, strobes held across three edges
module ccad_host_model (
   // clock
   input  wire logic        mclk,
   // card answers
   input  wire logic [15:0] dataOut,
   input  wire logic [1:0]  dataOe_n,
   input  wire logic        invalidAccess,
   input  wire logic        commonWrite,
   // host strobes and buses
   output logic             lowEn_n,
   output logic             highEn_n,
   output logic             attr_n,
   output logic             rdStb_n,
   output logic             wrStb_n,
   output logic [10:0]      address,
   output logic [15:0]      dataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   import ccad_pkg::*;
   logic [15:0] lastBus = 16'h0000;   // last level seen on the data lines

   // =====================================================================
   // idle bus at time zero
   // =====================================================================
   initial begin
      lowEn_n  = 1'b1;
      highEn_n = 1'b1;
      attr_n   = 1'b1;
      rdStb_n  = 1'b1;
      wrStb_n  = 1'b1;
      address  = 11'h000;
      dataIn   = 16'h0000;
   end

   // =====================================================================
   // one bus access; a released lane reads back as the inverse of last
   // =====================================================================
   task automatic access(input logic a_n, l_n, h_n, w, input logic [10:0] addr,
                         input logic [15:0] wdata, output logic [15:0] rdata,
                         output logic [1:0] oe, output logic inv, cw);
      @(posedge mclk);
      attr_n   <= a_n;
      lowEn_n  <= l_n;
      highEn_n <= h_n;
      address  <= addr;
      dataIn   <= w ? wdata : ~lastBus;
      rdStb_n  <= w;
      wrStb_n  <= ~w;
      @(posedge mclk);
      #1;
      cw = commonWrite;
      @(posedge mclk);
      #1;
      oe    = dataOe_n;
      inv   = invalidAccess;
      rdata = {dataOe_n[1] ? ~lastBus[15:8] : dataOut[15:8],
               dataOe_n[0] ? ~lastBus[7:0] : dataOut[7:0]};
      lastBus = w ? wdata : rdata;
      @(posedge mclk);
      rdStb_n  <= 1'b1;
      wrStb_n  <= 1'b1;
      lowEn_n  <= 1'b1;
      highEn_n <= 1'b1;
      dataIn   <= ~lastBus;
      // strobe stays high two full cycles before the next request
      @(posedge mclk);
   endtask : access
endmodule : ccad_host_model

/* File: testbench/card_config_attr_decode_bench.sv */
module card_config_attr_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ccad_pkg::*;
   // =====================================================================
   // rows: ctl is attr_n, low enable, high enable, write
   // =====================================================================
   typedef struct packed {
      logic [3:0]  ctl;
      logic [10:0] addr;
      logic [15:0] wdata;
      logic [15:0] expData;
      logic [1:0]  expOe;
      logic        expInv;
   } ccad_row_type;
   localparam ccad_row_type ROWS [23] = '{
      '{4'b0011, 11'h202, 16'h005a, 16'h0000, 2'h3, 1'b0},
      '{4'b0011, 11'h204, 16'h000c, 16'h0000, 2'h3, 1'b0},
      '{4'b0011, 11'h206, 16'h0033, 16'h0000, 2'h3, 1'b0},
      '{4'b0010, 11'h202, 16'h0000, 16'h005a, 2'h2, 1'b0},
      '{4'b0010, 11'h204, 16'h0000, 16'h000c, 2'h2, 1'b0},
      '{4'b0010, 11'h206, 16'h0000, 16'h0033, 2'h2, 1'b0},
      '{4'b0010, 11'h200, 16'h0000, 16'h0000, 2'h2, 1'b0},
      '{4'b0010, 11'h000, 16'h0000, 16'h00ff, 2'h2, 1'b0},
      '{4'b0010, 11'h1fe, 16'h0000, 16'h00ff, 2'h2, 1'b0},
      '{4'b0010, 11'h201, 16'h0000, 16'h0000, 2'h3, 1'b1},
      '{4'b0100, 11'h200, 16'h0000, 16'h0000, 2'h3, 1'b1},
      '{4'b0011, 11'h004, 16'h0011, 16'h0000, 2'h3, 1'b1},
      '{4'b0011, 11'h203, 16'h0022, 16'h0000, 2'h3, 1'b1},
      '{4'b0101, 11'h202, 16'h00ff, 16'h0000, 2'h3, 1'b1},
      '{4'b0010, 11'h202, 16'h0000, 16'h005a, 2'h2, 1'b0},
      '{4'b0010, 11'h400, 16'h0000, 16'h0000, 2'h3, 1'b1},
      '{4'b1010, 11'h010, 16'h0000, 16'hc3a5, 2'h2, 1'b0},
      '{4'b1100, 11'h010, 16'h0000, 16'hc3a5, 2'h1, 1'b0},
      '{4'b1000, 11'h010, 16'h0000, 16'hc3a5, 2'h0, 1'b0},
      '{4'b1000, 11'h011, 16'h0000, 16'h0000, 2'h3, 1'b1},
      '{4'b1001, 11'h020, 16'h1234, 16'h1234, 2'h3, 1'b0},
      '{4'b1011, 11'h030, 16'h00ab, 16'h00ab, 2'h3, 1'b0},
      '{4'b1001, 11'h021, 16'h5678, 16'h0000, 2'h3, 1'b1}};
   // bus and card signals
   logic          mclk           = 1'b0;
   logic          reset_n        = 1'b0;
   logic          cardReady      = 1'b0;
   logic          writeProtect   = 1'b0;
   logic [15:0]   commonReadData = 16'hc3a5;
   logic          lowEn_n, highEn_n, attr_n, rdStb_n, wrStb_n;
   logic [10:0]   address;
   logic [15:0]   dataIn, dataOut, commonWriteData, rd, m;
   logic [1:0]    dataOe_n, commonLanes, oe;
   logic          commonWrite, cardInReset, levelInterrupt, ioMode, invalidAccess;
   logic          inv, cw, cwExp;
   ccad_mode_type cardMode;
   int            fails = 0;
   int            check_count = 0;
   int            cycles = 0;

   // =====================================================================
   // clock, timeout and instances
   // =====================================================================
   always #5 mclk = ~mclk;
   // cut a hang short well past the expected run length
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         test_done();
      end
   end
   ccad_host_model u_host (.mclk(mclk), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .invalidAccess(invalidAccess), .commonWrite(commonWrite), .lowEn_n(lowEn_n),
      .highEn_n(highEn_n), .attr_n(attr_n), .rdStb_n(rdStb_n), .wrStb_n(wrStb_n),
      .address(address), .dataIn(dataIn));
   card_config_attr_decode #(.INFO_DEPTH(256)) u_dut (.mclk(mclk), .reset_n(reset_n),
      .low_byte_enable_n(lowEn_n), .high_byte_enable_n(highEn_n), .attrSelect_n(attr_n),
      .outputEnable_n(rdStb_n), .writeEnable_n(wrStb_n), .address(address),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
      .commonReadData(commonReadData), .commonWrite(commonWrite),
      .commonWriteData(commonWriteData), .commonLanes(commonLanes), .cardReady(cardReady),
      .writeProtect(writeProtect), .cardInReset(cardInReset),
      .levelInterrupt(levelInterrupt), .cardMode(cardMode), .ioMode(ioMode),
      .invalidAccess(invalidAccess));

   // =====================================================================
   // helpers
   // =====================================================================
   task automatic chk(input logic [15:0] got, exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // config space access on the low lane
   task automatic cfg(input logic w, input logic [10:0] a, input logic [15:0] d);
      u_host.access(1'b0, 1'b0, 1'b1, w, a, d, rd, oe, inv, cw);
   endtask : cfg
   task automatic note(input string name);
      $display("test %s done, checks %0d", name, check_count);
   endtask : note
   task automatic test_done();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // =====================================================================
   // main sequence
   // =====================================================================
   initial begin
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      chk(16'(dataOe_n), 16'h0003);
      chk({12'h0, cardInReset, levelInterrupt, cardMode}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         cfg(1'b0, CFG_BASE_ADDR + 11'(2 * i), 16'h0000);
         chk(16'(rd[7:0]), 16'h0000);
      end
      note("reset");
      // table of decode cases
      foreach (ROWS[i]) begin
         u_host.access(ROWS[i].ctl[3], ROWS[i].ctl[2], ROWS[i].ctl[1], ROWS[i].ctl[0],
                       ROWS[i].addr, ROWS[i].wdata, rd, oe, inv, cw);
         m = {{8{~ROWS[i].expOe[1]}}, {8{~ROWS[i].expOe[0]}}};
         chk(16'(oe), 16'(ROWS[i].expOe));
         chk(16'(inv), 16'(ROWS[i].expInv));
         chk(rd & m, ROWS[i].expData & m);
         cwExp = ROWS[i].ctl[3] & ROWS[i].ctl[0] & ~ROWS[i].expInv;
         chk(16'(cw), 16'(cwExp));
         m = {{8{~ROWS[i].ctl[1]}}, {8{~ROWS[i].ctl[2]}}};
         if (cwExp) begin
            chk(16'(commonLanes), {14'h0, ~ROWS[i].ctl[1], ~ROWS[i].ctl[2]});
            chk(commonWriteData & m, ROWS[i].expData & m);
         end
      end
      note("decode");
      // every card mode with level interrupts
      for (int i = 0; i < 4; i++) begin
         cfg(1'b1, OPTION_ADDR, 16'(i) | 16'h0040);
         chk(16'(cardMode), 16'(i));
         chk({14'h0, ioMode, levelInterrupt}, {14'h0, i != 0, 1'b1});
      end
      @(posedge mclk);
      cardReady <= 1'b1;
      cfg(1'b0, PINSUB_ADDR, 16'h0000);
      chk(16'(rd[7:0]), 16'h002c);
      cardReady    <= 1'b0;
      writeProtect <= 1'b1;
      cfg(1'b0, PINSUB_ADDR, 16'h0000);
      chk(16'(rd[7:0]), 16'h001c);
      cfg(1'b1, OPTION_ADDR, 16'h0000);
      chk({14'h0, ioMode, levelInterrupt}, 16'h0000);
      note("modes");
      // soft reset holds, then releases unconfigured
      cfg(1'b1, OPTION_ADDR, 16'h00c3);
      repeat (5) @(posedge mclk);
      #1;
      chk(16'(cardInReset), 16'h0001);
      cfg(1'b0, OPTION_ADDR, 16'h0000);
      chk(16'(rd[7:0]), 16'h00c3);
      cfg(1'b1, OPTION_ADDR, 16'h0043);
      chk({13'h0, cardInReset, cardMode}, 16'h0000);
      chk({14'h0, ioMode, levelInterrupt}, 16'h0000);
      note("soft reset");
      // hardware reset in mid-run clears the soft reset bit
      cfg(1'b1, OPTION_ADDR, 16'h0080);
      @(posedge mclk);
      reset_n <= 1'b0;
      @(posedge mclk);
      #1;
      chk({14'h0, cardInReset, dataOe_n[0]}, 16'h0001);
      @(posedge mclk);
      reset_n <= 1'b1;
      cfg(1'b0, OPTION_ADDR, 16'h0000);
      chk(16'(rd[7:0]), 16'h0000);
      note("hardware reset");
      // both enables high: strobes ignored, lanes released
      u_host.access(1'b0, 1'b1, 1'b1, 1'b1, STATE_ADDR, 16'h0077, rd, oe, inv, cw);
      u_host.access(1'b0, 1'b1, 1'b1, 1'b0, STATE_ADDR, 16'h0000, rd, oe, inv, cw);
      chk(16'(oe), 16'h0003);
      cfg(1'b0, STATE_ADDR, 16'h0000);
      chk(16'(rd[7:0]), 16'h0000);
      note("standby");
      test_done();
   end
endmodule : card_config_attr_decode_bench
